// File: inc/ttc_pkg.sv
// Operation
// R01 - timers tick clock/12, or /6 turbo
// R02 - twelve-clock option overrides all turbo bits
// R03 - function bit picks timer or counter
// R04 - two mode bits per timer select mode
// R05 - 13-bit mode uses high byte plus five
// R06 - count needs run and gate/int pin
// R07 - counter function counts pin falling edges
// R08 - 13-bit wrap to zero sets flag
// R09 - 16-bit wrap FFFF to zero sets flag
// R10 - 8-bit mode reloads low from high
// R11 - split: high byte uses timer one controls
// R12 - split mode freezes timer one
// R13 - timer one runs without run/flag bits
// R14 - third timer counts clock or pin
// R15 - capture mode: up count, wrap flag
// R16 - capture pin edge latches count, flags
// R17 - reload mode: wrap or pin reloads
// R18 - up/down direction from capture pin level
// R19 - down count reloads FFFF at match
// R20 - up/down reload: flag, toggle external flag
// R21 - baud mode reloads without overflow flag
// R22 - baud mode pin edge sets external flag
// R23 - flags sticky; writes land next clock
package ttc_pkg;
  localparam int AW = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CLK = 8'h08;
  localparam logic [7:0] OFS_CNT0 = 8'h0c;
  localparam logic [7:0] OFS_CNT1 = 8'h10;
  localparam logic [7:0] OFS_CNT2 = 8'h14;
  localparam logic [7:0] OFS_RCAP = 8'h18;
  localparam logic [7:0] OFS_T2CTRL = 8'h1c;
  localparam logic [7:0] OFS_T2MODE = 8'h20;
  // timer_mode_reg fields
  localparam int MODE0_LO = 0;
  localparam int CT0 = 2;
  localparam int GATE0 = 3;
  localparam int MODE1_LO = 4;
  localparam int CT1 = 6;
  localparam int GATE1 = 7;
  // timer_control_reg fields
  localparam int RUN0 = 4;
  localparam int OVF0 = 5;
  localparam int RUN1 = 6;
  localparam int OVF1 = 7;
  // clock_control_reg fields
  localparam int OPT12 = 0;
  localparam int TURBO0 = 3;
  localparam int TURBO1 = 4;
  localparam int TURBO2 = 5;
  // third_timer_ctrl_reg fields
  localparam int CPRL = 0;
  localparam int CTS2 = 1;
  localparam int RUN2 = 2;
  localparam int EXEN = 3;
  localparam int TXB = 4;
  localparam int RXB = 5;
  localparam int EXF = 6;
  localparam int OVF2 = 7;
  // third_timer_mode_reg field
  localparam int DOWN_EN = 0;
  // synchronised pin indices
  localparam int NPIN = 6;
  localparam int P_CNT0 = 0;
  localparam int P_CNT1 = 1;
  localparam int P_CNT2 = 2;
  localparam int P_EX = 3;
  localparam int P_I0 = 4;
  localparam int P_I1 = 5;
  // prescale: machine cycle of twelve clocks
  localparam logic [3:0] PRE_LAST = 4'hb;
  localparam logic [3:0] PRE_HALF = 4'h5;
  localparam logic [1:0] MD13 = 2'h0;
  localparam logic [1:0] MD16 = 2'h1;
  localparam logic [1:0] MD8R = 2'h2;
  localparam logic [1:0] MDSPLIT = 2'h3;
  localparam logic [15:0] ALL1 = 16'hffff;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
endpackage : ttc_pkg

// File: design/ttc_timer_unit.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ttc_timer_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ttc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic third_timer_count_pin,
  input wire logic capture_direction_pin,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  output logic timer_zero_ovf,
  output logic timer_one_ovf,
  output logic third_timer_ovf,
  output logic third_ext_req
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] timer_mode_reg, next_timer_mode_reg;
  logic [7:0] timer_control_reg, next_timer_control_reg;
  logic [7:0] clock_control_reg, next_clock_control_reg;
  logic [7:0] third_timer_ctrl_reg, next_third_timer_ctrl_reg;
  logic [7:0] third_timer_mode_reg, next_third_timer_mode_reg;
  logic [15:0] count0, next_count0;
  logic [15:0] count1, next_count1;
  logic [15:0] count2, next_count2;
  logic [15:0] reload_capture, next_reload_capture;
  logic [3:0] pre, next_pre;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_ext_req;
  logic [ttc_pkg::NPIN-1:0] pins, s1, s2, s3;
  logic [ttc_pkg::NPIN-1:0] next_s1, next_s2, next_s3;
  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  logic tick12, tick6, tk0, tk1, tk2;
  logic [ttc_pkg::NPIN-1:0] fall;
  logic split0, en0, en1, src0, src1, inc0, inc1, inc2;
  logic ov0, ov1, baud, updown, edge2, wr, rd_setup;
  logic [16:0] st0, st1;
  logic [1:0] md0, md1;

  // count low five bits, whole word or low byte used as 13-bit/16-bit/8-bit step by mode
  function automatic logic [16:0] step(input logic [1:0] md,
                                       input logic [15:0] c);
    logic [5:0] lo5;
    logic [8:0] lo8;
    logic [16:0] r;
    lo5 = {1'b0, c[4:0]} + 6'h01;
    lo8 = {1'b0, c[7:0]} + 9'h001;
    r = {1'b0, c};
    case (md)
      // R05 13-bit layout
      ttc_pkg::MD13: begin
        if (lo5[5]) begin
          r = {c[15:8] == 8'hff, c[15:8] + 8'h01, c[7:5], 5'h00};
        end else begin
          r = {1'b0, c[15:5], lo5[4:0]};
        end
      end
      // R09 full 16-bit wrap
      ttc_pkg::MD16: r = {c == ttc_pkg::ALL1, c + 16'h0001};
      // R10 low byte reloads from high
      ttc_pkg::MD8R: begin
        if (lo8[8]) begin
          r = {1'b1, c[15:8], c[15:8]};
        end else begin
          r = {1'b0, c[15:8], lo8[7:0]};
        end
      end
      default: r = {lo8[8], c[15:8], lo8[7:0]};
    endcase
    return r;
  endfunction : step

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  assign pins = {ext_irq_one_pin, ext_irq_zero_pin, capture_direction_pin,
                 third_timer_count_pin, timer_one_count_pin,
                 timer_zero_count_pin};

  // third stage only feeds the edge detect; s1 read by s2 alone
  genvar gi;
  generate
    for (gi = 0; gi < ttc_pkg::NPIN; gi++) begin : g_sync
      always_comb begin
        next_s1[gi] = pins[gi];
        next_s2[gi] = s1[gi];
        next_s3[gi] = s2[gi];
        // R07 falling edge of pin
        fall[gi] = s3[gi] & ~s2[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // ----------------------------------------
  // timers and register file
  // ----------------------------------------
  always_comb begin
    next_timer_mode_reg = timer_mode_reg;
    next_timer_control_reg = timer_control_reg;
    next_clock_control_reg = clock_control_reg;
    next_third_timer_ctrl_reg = third_timer_ctrl_reg;
    next_third_timer_mode_reg = third_timer_mode_reg;
    next_count0 = count0;
    next_count1 = count1;
    next_count2 = count2;
    next_reload_capture = reload_capture;
    // R01 machine-cycle prescale
    tick12 = (pre == ttc_pkg::PRE_LAST);
    tick6 = tick12 | (pre == ttc_pkg::PRE_HALF);
    next_pre = tick12 ? 4'h0 : pre + 4'h1;
    // R02 option forces divide by twelve
    tk0 = clock_control_reg[ttc_pkg::OPT12] ? tick12 :
          (clock_control_reg[ttc_pkg::TURBO0] ? tick6 : tick12);
    tk1 = clock_control_reg[ttc_pkg::OPT12] ? tick12 :
          (clock_control_reg[ttc_pkg::TURBO1] ? tick6 : tick12);
    tk2 = clock_control_reg[ttc_pkg::OPT12] ? tick12 :
          (clock_control_reg[ttc_pkg::TURBO2] ? tick6 : tick12);
    // R04 per-timer mode select
    md0 = timer_mode_reg[ttc_pkg::MODE0_LO +: 2];
    md1 = timer_mode_reg[ttc_pkg::MODE1_LO +: 2];
    split0 = (md0 == ttc_pkg::MDSPLIT);
    // R03 timer or counter function
    src0 = timer_mode_reg[ttc_pkg::CT0] ? fall[ttc_pkg::P_CNT0] : tk0;
    src1 = timer_mode_reg[ttc_pkg::CT1] ? fall[ttc_pkg::P_CNT1] : tk1;
    // R06 run and gate qualify counting
    en0 = timer_control_reg[ttc_pkg::RUN0] &
          (~timer_mode_reg[ttc_pkg::GATE0] | s2[ttc_pkg::P_I0]);
    // R13 run bit dropped while timer zero split
    // R12 split mode on timer one freezes it
    en1 = (split0 | timer_control_reg[ttc_pkg::RUN1]) &
          (~timer_mode_reg[ttc_pkg::GATE1] | s2[ttc_pkg::P_I1]) &
          (md1 != ttc_pkg::MDSPLIT);
    inc0 = en0 & src0;
    inc1 = en1 & src1;
    st0 = step(md0, count0);
    st1 = step(md1, count1);
    ov0 = inc0 & st0[16];
    ov1 = inc1 & st1[16];
    if (inc0) begin
      next_count0 = st0[15:0];
    end
    // R11 high byte counts cycles on timer one controls
    if (split0 && timer_control_reg[ttc_pkg::RUN1] && tk0) begin
      next_count0[15:8] = count0[15:8] + 8'h01;
    end
    if (inc1) begin
      next_count1 = st1[15:0];
    end
    // third timer
    baud = third_timer_ctrl_reg[ttc_pkg::RXB] |
           third_timer_ctrl_reg[ttc_pkg::TXB];
    updown = ~baud & ~third_timer_ctrl_reg[ttc_pkg::CPRL] &
             third_timer_mode_reg[ttc_pkg::DOWN_EN];
    // R14 clock or pin source
    inc2 = third_timer_ctrl_reg[ttc_pkg::RUN2] &
           (third_timer_ctrl_reg[ttc_pkg::CTS2] ? fall[ttc_pkg::P_CNT2] : tk2);
    edge2 = third_timer_ctrl_reg[ttc_pkg::EXEN] & fall[ttc_pkg::P_EX];
    // apb: no wait state, read data captured in setup, writes in access
    rd_setup = psel & ~penable;
    wr = psel & penable & pready & pwrite;
    next_pready = rd_setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    // R23 software write lands this edge, before hardware sets
    if (wr) begin
      case (paddr)
        ttc_pkg::OFS_MODE: next_timer_mode_reg = pwdata[7:0];
        ttc_pkg::OFS_CTRL: next_timer_control_reg = pwdata[7:0];
        ttc_pkg::OFS_CLK: next_clock_control_reg = pwdata[7:0];
        ttc_pkg::OFS_T2CTRL: next_third_timer_ctrl_reg = pwdata[7:0];
        ttc_pkg::OFS_T2MODE: next_third_timer_mode_reg = pwdata[7:0];
        default: next_pre = next_pre;
      endcase
    end
    if (baud) begin
      // R21 auto-reload, no overflow flag
      if (inc2) begin
        next_count2 = (count2 == ttc_pkg::ALL1) ? reload_capture :
                      count2 + 16'h0001;
      end
      // R22 pin edge sets external flag
      if (edge2) begin
        next_third_timer_ctrl_reg[ttc_pkg::EXF] = 1'b1;
      end
    end else if (third_timer_ctrl_reg[ttc_pkg::CPRL]) begin
      // R15 free 16-bit up count
      if (inc2) begin
        next_count2 = count2 + 16'h0001;
        if (count2 == ttc_pkg::ALL1) begin
          next_third_timer_ctrl_reg[ttc_pkg::OVF2] = 1'b1;
        end
      end
      // R16 capture on pin edge
      if (edge2) begin
        next_reload_capture = count2;
        next_third_timer_ctrl_reg[ttc_pkg::EXF] = 1'b1;
      end
    end else if (updown) begin
      if (inc2) begin
        // R18 direction from pin level
        if (s2[ttc_pkg::P_EX]) begin
          next_count2 = count2 + 16'h0001;
          if (count2 == ttc_pkg::ALL1) begin
            next_count2 = reload_capture;
            // R20 reload flags, external flag toggles
            next_third_timer_ctrl_reg[ttc_pkg::OVF2] = 1'b1;
            next_third_timer_ctrl_reg[ttc_pkg::EXF] =
              ~next_third_timer_ctrl_reg[ttc_pkg::EXF];
          end
        end else begin
          next_count2 = count2 - 16'h0001;
          // R19 down count match reloads all ones
          if (count2 == reload_capture) begin
            next_count2 = ttc_pkg::ALL1;
            next_third_timer_ctrl_reg[ttc_pkg::OVF2] = 1'b1;
            next_third_timer_ctrl_reg[ttc_pkg::EXF] =
              ~next_third_timer_ctrl_reg[ttc_pkg::EXF];
          end
        end
      end
    end else begin
      // R17 reload on wrap or pin edge
      if (inc2) begin
        next_count2 = count2 + 16'h0001;
        if (count2 == ttc_pkg::ALL1) begin
          next_count2 = reload_capture;
          next_third_timer_ctrl_reg[ttc_pkg::OVF2] = 1'b1;
        end
      end
      if (edge2) begin
        next_count2 = reload_capture;
        next_third_timer_ctrl_reg[ttc_pkg::EXF] = 1'b1;
      end
    end
    // R08 overflow flag of timer zero
    if (ov0) begin
      next_timer_control_reg[ttc_pkg::OVF0] = 1'b1;
    end
    // R11 split high byte owns timer one flag
    if (split0 && timer_control_reg[ttc_pkg::RUN1] && tk0 &&
        count0[15:8] == 8'hff) begin
      next_timer_control_reg[ttc_pkg::OVF1] = 1'b1;
    end
    // R13 timer one flag only when not split
    if (ov1 && !split0) begin
      next_timer_control_reg[ttc_pkg::OVF1] = 1'b1;
    end
    // count writes win over the increment
    if (wr) begin
      case (paddr)
        ttc_pkg::OFS_CNT0: next_count0 = pwdata[15:0];
        ttc_pkg::OFS_CNT1: next_count1 = pwdata[15:0];
        ttc_pkg::OFS_CNT2: next_count2 = pwdata[15:0];
        ttc_pkg::OFS_RCAP: next_reload_capture = pwdata[15:0];
        default: next_pre = next_pre;
      endcase
    end
    // R20 no external request in up/down mode
    next_ext_req = next_third_timer_ctrl_reg[ttc_pkg::EXF] & ~updown;
    if (rd_setup) begin
      case (paddr)
        ttc_pkg::OFS_MODE: next_prdata = {24'h0, timer_mode_reg};
        ttc_pkg::OFS_CTRL: next_prdata = {24'h0, timer_control_reg};
        ttc_pkg::OFS_CLK: next_prdata = {24'h0, clock_control_reg};
        ttc_pkg::OFS_CNT0: next_prdata = {16'h0, count0};
        ttc_pkg::OFS_CNT1: next_prdata = {16'h0, count1};
        ttc_pkg::OFS_CNT2: next_prdata = {16'h0, count2};
        ttc_pkg::OFS_RCAP: next_prdata = {16'h0, reload_capture};
        ttc_pkg::OFS_T2CTRL: next_prdata = {24'h0, third_timer_ctrl_reg};
        ttc_pkg::OFS_T2MODE: next_prdata = {24'h0, third_timer_mode_reg};
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg <= ttc_pkg::RST8;
      timer_control_reg <= ttc_pkg::RST8;
      clock_control_reg <= ttc_pkg::RST8;
      third_timer_ctrl_reg <= ttc_pkg::RST8;
      third_timer_mode_reg <= ttc_pkg::RST8;
      count0 <= ttc_pkg::RST16;
      count1 <= ttc_pkg::RST16;
      count2 <= ttc_pkg::RST16;
      reload_capture <= ttc_pkg::RST16;
      pre <= 4'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      third_ext_req <= 1'b0;
    end else begin
      timer_mode_reg <= next_timer_mode_reg;
      timer_control_reg <= next_timer_control_reg;
      clock_control_reg <= next_clock_control_reg;
      third_timer_ctrl_reg <= next_third_timer_ctrl_reg;
      third_timer_mode_reg <= next_third_timer_mode_reg;
      count0 <= next_count0;
      count1 <= next_count1;
      count2 <= next_count2;
      reload_capture <= next_reload_capture;
      pre <= next_pre;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      third_ext_req <= next_ext_req;
    end
  end

  assign timer_zero_ovf = timer_control_reg[ttc_pkg::OVF0];
  assign timer_one_ovf = timer_control_reg[ttc_pkg::OVF1];
  assign third_timer_ovf = third_timer_ctrl_reg[ttc_pkg::OVF2];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prescale_period: assert property ( // R01
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("prescale period not twelve");
  a_opt_twelve: assert property ( // R02
    clock_control_reg[ttc_pkg::OPT12] |-> (tk0 == tick12 && tk2 == tick12))
    else $error("turbo not overridden");
  a_gate_hold: assert property ( // R06
    (!en0 && !split0 && !wr) |=> $stable(count0))
    else $error("timer zero counted while disabled");
  a_wrap_13: assert property ( // R08
    (inc0 && md0 == ttc_pkg::MD13 && count0[15:8] == 8'hff &&
     count0[4:0] == 5'h1f && !wr)
    |=> (count0[15:8] == 8'h00 && count0[4:0] == 5'h00 && timer_zero_ovf))
    else $error("13-bit wrap wrong");
  a_wrap_16: assert property ( // R09
    (inc0 && md0 == ttc_pkg::MD16 && count0 == ttc_pkg::ALL1 && !wr)
    |=> (count0 == 16'h0000 && timer_zero_ovf))
    else $error("16-bit wrap wrong");
  a_reload_8: assert property ( // R10
    (inc0 && md0 == ttc_pkg::MD8R && count0[7:0] == 8'hff && !wr)
    |=> (count0[7:0] == $past(count0[15:8]) && timer_zero_ovf))
    else $error("8-bit reload wrong");
  a_one_frozen: assert property ( // R12
    (md1 == ttc_pkg::MDSPLIT && !wr) |=> $stable(count1))
    else $error("timer one moved in split mode");
  a_capture_edge: assert property ( // R16
    (edge2 && !baud && third_timer_ctrl_reg[ttc_pkg::CPRL] && !wr)
    |=> (reload_capture == $past(count2) &&
         third_timer_ctrl_reg[ttc_pkg::EXF]))
    else $error("capture failed");
  a_down_reload: assert property ( // R19
    (updown && inc2 && !s2[ttc_pkg::P_EX] && count2 == reload_capture &&
     !wr) |=> (count2 == ttc_pkg::ALL1 && third_timer_ovf))
    else $error("down count reload wrong");
  a_baud_noflag: assert property ( // R21
    (baud && !third_timer_ovf && !wr) |=> !third_timer_ovf)
    else $error("baud mode set overflow flag");
endmodule : ttc_timer_unit
`default_nettype wire

// File: sim/ttc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// board-side pins: count, gate, capture
// ----------------------------------------
module ttc_pin_model (
  input wire logic pclk,
  output logic timer_zero_count_pin,
  output logic timer_one_count_pin,
  output logic third_timer_count_pin,
  output logic capture_direction_pin,
  output logic ext_irq_zero_pin,
  output logic ext_irq_one_pin
);
  logic [ttc_pkg::NPIN-1:0] lvl;

  initial begin
    lvl = '1;
  end

  assign timer_zero_count_pin = lvl[ttc_pkg::P_CNT0];
  assign timer_one_count_pin = lvl[ttc_pkg::P_CNT1];
  assign third_timer_count_pin = lvl[ttc_pkg::P_CNT2];
  assign capture_direction_pin = lvl[ttc_pkg::P_EX];
  assign ext_irq_zero_pin = lvl[ttc_pkg::P_I0];
  assign ext_irq_one_pin = lvl[ttc_pkg::P_I1];

  // levels held 4 clocks: the design needs 2 and syncs 3 edges
  task automatic fall_pulse(input int idx);
    lvl[idx] <= 1'b0;
    repeat (4) @(posedge pclk);
    lvl[idx] <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : fall_pulse

  task automatic set_level(input int idx, input logic v);
    lvl[idx] <= v;
    repeat (4) @(posedge pclk);
  endtask : set_level
endmodule : ttc_pin_model
`default_nettype wire

// File: sim/ttc_timer_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ttc_timer_unit_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, rerr, t0f, t1f, t2f, xreq;
  logic p_t0, p_t1, p_t2, p_ex, p_i0, p_i1;
  int n_fail = 0;
  int tests_run = 0;

  always #2.5 pclk = ~pclk;

  ttc_timer_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_zero_count_pin(p_t0), .timer_one_count_pin(p_t1),
    .third_timer_count_pin(p_t2), .capture_direction_pin(p_ex),
    .ext_irq_zero_pin(p_i0), .ext_irq_one_pin(p_i1),
    .timer_zero_ovf(t0f), .timer_one_ovf(t1f), .third_timer_ovf(t2f),
    .third_ext_req(xreq));

  ttc_pin_model i_pins (.pclk(pclk), .timer_zero_count_pin(p_t0),
    .timer_one_count_pin(p_t1), .third_timer_count_pin(p_t2),
    .capture_direction_pin(p_ex), .ext_irq_zero_pin(p_i0),
    .ext_irq_one_pin(p_i1));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    n_fail++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("got %h want %h", got, exp));
  endtask : chk_eq

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    tests_run++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      fail($sformatf("got %0d want %0d..%0d", got, lo, hi));
    end
  endtask : chk_rng

  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction : b

  // apb master: hold until pready sampled high, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) fail("no pready");
  endtask : apb

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values and unmapped access
  task automatic t_reset_map;
    do_reset();
    rd(ttc_pkg::OFS_CNT0);
    chk_eq(rdat, 32'h0);
    apb(1'b1, 8'hfc, 32'hffff);
    chk_eq({31'h0, rerr}, 32'h1);
    rd(8'hfc);
    chk_eq({31'h0, rerr}, 32'h1);
  endtask : t_reset_map

  // 13-bit counter wrap, flag sticky until cleared
  task automatic t_mode13;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_MODE, b(ttc_pkg::CT0));
    apb(1'b1, ttc_pkg::OFS_CNT0, 32'hff1f);
    apb(1'b1, ttc_pkg::OFS_CTRL, b(ttc_pkg::RUN0));
    i_pins.fall_pulse(ttc_pkg::P_CNT0);
    rd(ttc_pkg::OFS_CNT0);
    chk_eq(rdat & 32'hff1f, 32'h0);
    chk_eq({31'h0, t0f}, 32'h1);
    apb(1'b1, ttc_pkg::OFS_CTRL, 32'h0);
    chk_eq({31'h0, t0f}, 32'h0);
  endtask : t_mode13

  // gate blocks count, 16-bit wrap on timer one
  task automatic t_gate16;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_MODE,
      b(ttc_pkg::MODE1_LO) | b(ttc_pkg::CT1) | b(ttc_pkg::GATE1));
    apb(1'b1, ttc_pkg::OFS_CNT1, 32'hffff);
    apb(1'b1, ttc_pkg::OFS_CTRL, b(ttc_pkg::RUN1));
    i_pins.set_level(ttc_pkg::P_I1, 1'b0);
    i_pins.fall_pulse(ttc_pkg::P_CNT1);
    rd(ttc_pkg::OFS_CNT1);
    chk_eq(rdat, 32'hffff);
    i_pins.set_level(ttc_pkg::P_I1, 1'b1);
    i_pins.fall_pulse(ttc_pkg::P_CNT1);
    rd(ttc_pkg::OFS_CNT1);
    chk_eq(rdat, 32'h0);
    chk_eq({31'h0, t1f}, 32'h1);
  endtask : t_gate16

  task automatic t_reload8;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_MODE, {30'h0, ttc_pkg::MD8R} | b(ttc_pkg::CT0));
    apb(1'b1, ttc_pkg::OFS_CNT0, 32'h80ff);
    apb(1'b1, ttc_pkg::OFS_CTRL, b(ttc_pkg::RUN0));
    i_pins.fall_pulse(ttc_pkg::P_CNT0);
    rd(ttc_pkg::OFS_CNT0);
    chk_eq(rdat, 32'h8080);
    chk_eq({31'h0, t0f}, 32'h1);
  endtask : t_reload8

  // prescale rates; two ticks of slack for phase
  task automatic t_rates;
    logic [31:0] clk_sel [3];
    int exp [3];
    clk_sel = '{32'h0, b(ttc_pkg::TURBO0),
      b(ttc_pkg::TURBO0) | b(ttc_pkg::OPT12)};
    exp = '{20, 40, 20};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      apb(1'b1, ttc_pkg::OFS_MODE, {30'h0, ttc_pkg::MD16});
      apb(1'b1, ttc_pkg::OFS_CLK, clk_sel[i]);
      // starts at all ones: first tick wraps and flags
      apb(1'b1, ttc_pkg::OFS_CNT0, 32'hffff);
      apb(1'b1, ttc_pkg::OFS_CTRL, b(ttc_pkg::RUN0));
      repeat (237) @(posedge pclk);
      chk_eq({31'h0, t0f}, 32'h1);
      apb(1'b1, ttc_pkg::OFS_CTRL, 32'h0);
      rd(ttc_pkg::OFS_CNT0);
      chk_rng(rdat, exp[i] - 2, exp[i]);
    end
  endtask : t_rates

  // split: high byte on run1, timer one frozen
  task automatic t_split;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_MODE, 32'h33);
    apb(1'b1, ttc_pkg::OFS_CTRL, b(ttc_pkg::RUN1));
    repeat (240) @(posedge pclk);
    rd(ttc_pkg::OFS_CNT0);
    chk_rng(rdat >> 8, 19, 21);
    chk_eq(rdat & 32'hff, 32'h0);
    rd(ttc_pkg::OFS_CNT1);
    chk_eq(rdat, 32'h0);
    apb(1'b1, ttc_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, ttc_pkg::OFS_MODE, 32'h13);
    apb(1'b1, ttc_pkg::OFS_CNT1, 32'hffff);
    repeat (24) @(posedge pclk);
    rd(ttc_pkg::OFS_CNT1);
    chk_rng(rdat, 1, 2);
    chk_eq({31'h0, t1f}, 32'h0);
  endtask : t_split

  task automatic t_capture;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_T2CTRL, b(ttc_pkg::CPRL) | b(ttc_pkg::CTS2) |
      b(ttc_pkg::RUN2) | b(ttc_pkg::EXEN));
    apb(1'b1, ttc_pkg::OFS_CNT2, 32'hfffe);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    i_pins.fall_pulse(ttc_pkg::P_EX);
    rd(ttc_pkg::OFS_RCAP);
    chk_eq(rdat, 32'hffff);
    chk_eq({31'h0, xreq}, 32'h1);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'h0);
    chk_eq({31'h0, t2f}, 32'h1);
  endtask : t_capture

  // up reload on wrap and on pin edge
  task automatic t_reload_up;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_RCAP, 32'h4000);
    apb(1'b1, ttc_pkg::OFS_CNT2, 32'hffff);
    apb(1'b1, ttc_pkg::OFS_T2CTRL,
      b(ttc_pkg::CTS2) | b(ttc_pkg::RUN2) | b(ttc_pkg::EXEN));
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'h4001);
    chk_eq({31'h0, t2f}, 32'h1);
    i_pins.fall_pulse(ttc_pkg::P_EX);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'h4000);
    chk_eq({31'h0, xreq}, 32'h1);
  endtask : t_reload_up

  // up/down: reload both ways, flag toggles, no request
  task automatic t_updown;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_T2MODE, b(ttc_pkg::DOWN_EN));
    apb(1'b1, ttc_pkg::OFS_RCAP, 32'h4000);
    apb(1'b1, ttc_pkg::OFS_CNT2, 32'h4001);
    apb(1'b1, ttc_pkg::OFS_T2CTRL, b(ttc_pkg::CTS2) | b(ttc_pkg::RUN2));
    i_pins.set_level(ttc_pkg::P_EX, 1'b0);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    rd(ttc_pkg::OFS_T2CTRL);
    chk_eq(rdat & (b(ttc_pkg::EXF) | b(ttc_pkg::OVF2)),
      b(ttc_pkg::EXF) | b(ttc_pkg::OVF2));
    chk_eq({31'h0, xreq}, 32'h0);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'hffff);
    i_pins.set_level(ttc_pkg::P_EX, 1'b1);
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'h4000);
    rd(ttc_pkg::OFS_T2CTRL);
    chk_eq(rdat & b(ttc_pkg::EXF), 32'h0);
  endtask : t_updown

  // baud mode: reload without flag, pin sets request
  task automatic t_baud;
    do_reset();
    apb(1'b1, ttc_pkg::OFS_RCAP, 32'h1000);
    apb(1'b1, ttc_pkg::OFS_CNT2, 32'hffff);
    apb(1'b1, ttc_pkg::OFS_T2CTRL, b(ttc_pkg::TXB) | b(ttc_pkg::CTS2) |
      b(ttc_pkg::RUN2) | b(ttc_pkg::EXEN));
    i_pins.fall_pulse(ttc_pkg::P_CNT2);
    rd(ttc_pkg::OFS_CNT2);
    chk_eq(rdat, 32'h1000);
    chk_eq({31'h0, t2f}, 32'h0);
    i_pins.fall_pulse(ttc_pkg::P_EX);
    chk_eq({31'h0, xreq}, 32'h1);
  endtask : t_baud

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    do_reset();
    t_reset_map();
    t_mode13();
    t_gate16();
    t_reload8();
    t_rates();
    t_split();
    t_capture();
    t_reload_up();
    t_updown();
    t_baud();
    stop_test();
  end

  // roughly 1.5k cycles expected; generous margin
  initial begin
    #200000;
    fail("timeout");
    stop_test();
  end
endmodule : ttc_timer_unit_tb
`default_nettype wire
